// ---- design/fsp_cycle.sv ----
// One flash bus cycle: read or write strobe of fixed width.
// Assumes the caller holds addr and data stable while busy.
`default_nettype none
module fsp_cycle
	import fsp_pkg::*;
(
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              rstn,
	// Request
	input  wire logic              start,
	input  wire logic              is_write,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wdata,
	// Flash pins
	input  wire logic [DATA_W-1:0] dq_in,
	output fsp_pkg::fsp_bus_t      bus,
	// Status
	output logic                   busy,
	output logic                   done,
	output logic [DATA_W-1:0]      rdata
);
	import fsp_pkg::*;
	logic [7:0] cnt;
	wire        last = (cnt == 8'h01);
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			cnt   <= 8'h00;
			busy  <= 1'b0;
			done  <= 1'b0;
			rdata <= '0;
			bus   <= '{addr: '0, dq_out: '0, dq_oe_n: 1'b1, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
		end else begin
			done <= 1'b0;
			if (start && !busy) begin
				busy        <= 1'b1;
				cnt         <= STROBE_CNT;
				bus.addr    <= addr;
				bus.dq_out  <= wdata;
				bus.dq_oe_n <= !is_write;
				bus.ce_n    <= 1'b0;
				// Strobe wide enough to clear the glitch filter
				bus.we_n    <= !is_write;
				bus.oe_n    <= is_write;
			end else if (busy) begin
				cnt <= cnt - 8'h01;
				if (last) begin
					busy        <= 1'b0;
					done        <= 1'b1;
					rdata       <= dq_in;
					bus.ce_n    <= 1'b1;
					bus.we_n    <= 1'b1;
					bus.oe_n    <= 1'b1;
					bus.dq_oe_n <= 1'b1;
				end
			end
		end
	end
endmodule // fsp_cycle
`default_nettype wire

// ---- design/fsp_host.sv ----
// Host-side controller for a NOR flash with group protection and a
// secured region; drives the flash pins and screens user requests.
// Assumes one user request at a time, held until accepted.
`default_nettype none
module fsp_host
	import fsp_pkg::*;
(
	// Clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  rstn,
	// User request
	input  wire logic                  req_valid,
	input  wire fsp_pkg::fsp_req_t     req,
	output logic                       req_ready,
	// User answer
	output logic                       resp_valid,
	output logic [fsp_pkg::DATA_W-1:0] resp_data,
	output logic                       resp_refused,
	// Status
	input  wire logic                  temp_unprotect,
	input  wire logic                  supply_ok,
	output logic [31:0]                group_protected,
	output logic                       secured_region_mode,
	output logic                       secured_region_locked,
	// Flash pins
	input  wire logic [fsp_pkg::DATA_W-1:0] dq_in,
	output fsp_pkg::fsp_bus_t          flash_bus,
	output logic                       flash_reset_n
);
	import fsp_pkg::*;
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef enum logic [4:0] {
		FSP_IDLE  = 5'b00001,
		FSP_SEQ   = 5'b00010,
		FSP_WAIT  = 5'b00100,
		FSP_ANS   = 5'b01000,
		FSP_RESET = 5'b10000
	} fsp_state_t;
	fsp_state_t        state;
	fsp_req_t          cur;
	logic [1:0]        step;
	logic [1:0]        nsteps;
	logic              cyc_start;
	logic              cyc_write;
	logic [ADDR_W-1:0] cyc_addr;
	logic [DATA_W-1:0] cyc_data;
	logic              cyc_busy;
	logic              cyc_done;
	logic [DATA_W-1:0] cyc_rdata;
	logic              refused;
	fsp_bus_t          bus_i;
	// ----------------------------------------
	// Decode
	// ----------------------------------------
	wire [GROUP_W-1:0] req_group = req.addr[GROUP_LSB +: GROUP_W];
	wire               grp_prot  = group_protected[req_group] && !temp_unprotect;
	wire               sr_target = secured_region_mode && (req_group == '0);
	wire               sr_block  = sr_target && secured_region_locked;
	wire               is_wr     = (req.op == FSP_OP_WRITE);
	wire               refuse_now = is_wr && (grp_prot || sr_block || !supply_ok);
	wire               start_req = req_valid && req_ready;
	// Per-step address and data of the command sequences
	wire [2:0]  seq_op   = cur.op;
	wire [ADDR_W-1:0] seq_addr = (step == 2'd1) ? UNLOCK_A2 : UNLOCK_A1;
	wire [DATA_W-1:0] seq_data =
		(step == 2'd0) ? CMD_ENTER_1 :
		(step == 2'd1) ? CMD_ENTER_2 :
		(seq_op == FSP_OP_ENTER) ? CMD_ENTER_3 :
		(step == 2'd2) ? CMD_EXIT_3 : CMD_EXIT_4;
	wire        seq_cmd  = (seq_op == FSP_OP_ENTER) || (seq_op == FSP_OP_EXIT);
	wire        seq_last = (step == nsteps);
	// ----------------------------------------
	// Cycle request selection
	// ----------------------------------------
	// Bus cycles per request, minus one
	wire [1:0]        req_nsteps   = (req.op == FSP_OP_EXIT)  ? 2'd3 :
	                                 (req.op == FSP_OP_ENTER) ? 2'd2 : 2'd0;
	wire              cyc_is_wr    = seq_cmd || (cur.op == FSP_OP_WRITE);
	wire [ADDR_W-1:0] cyc_addr_sel = seq_cmd ? seq_addr : cur.addr;
	wire [DATA_W-1:0] cyc_data_sel = seq_cmd ? seq_data : cur.data;
	wire [DATA_W-1:0] ans_data     = refused ? '0 : cyc_rdata;
	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			state         <= FSP_RESET;
			cur           <= '0;
			step          <= 2'd0;
			nsteps        <= 2'd0;
			req_ready     <= 1'b0;
			resp_valid    <= 1'b0;
			resp_data     <= '0;
			resp_refused  <= 1'b0;
			refused       <= 1'b0;
			cyc_start     <= 1'b0;
			cyc_write     <= 1'b0;
			cyc_addr      <= '0;
			cyc_data      <= '0;
			flash_reset_n <= 1'b0;
		end else begin
			cyc_start  <= 1'b0;
			resp_valid <= 1'b0;
			unique case (state)
				FSP_RESET: begin
					// Pulse flash reset: drops secured-region mode
					flash_reset_n <= 1'b1;
					req_ready     <= 1'b1;
					state         <= FSP_IDLE;
				end
				FSP_IDLE: begin
					if (start_req) begin
						req_ready <= 1'b0;
						cur       <= req;
						step      <= 2'd0;
						refused   <= refuse_now;
						nsteps    <= req_nsteps;
						state     <= refuse_now ? FSP_ANS : FSP_SEQ;
					end
				end
				FSP_SEQ: begin
					// Never restart a cycle that is still strobing
					if (!cyc_busy) begin
						cyc_start <= 1'b1;
						cyc_write <= cyc_is_wr;
						cyc_addr  <= cyc_addr_sel;
						cyc_data  <= cyc_data_sel;
						state     <= FSP_WAIT;
					end
				end
				FSP_WAIT: begin
					if (cyc_done) begin
						step  <= step + 2'd1;
						state <= seq_last ? FSP_ANS : FSP_SEQ;
					end
				end
				FSP_ANS: begin
					resp_valid   <= 1'b1;
					resp_refused <= refused;
					resp_data    <= ans_data;
					req_ready    <= 1'b1;
					state        <= FSP_IDLE;
				end
			endcase
		end
	end
	// ----------------------------------------
	// Protection and mode tracking
	// ----------------------------------------
	wire ans_ok    = (state == FSP_ANS) && !refused;
	wire vfy_done  = ans_ok && (cur.op == FSP_OP_VERIFY);
	wire vfy_prot  = (cyc_rdata == VERIFY_PROT);
	wire [GROUP_W-1:0] cur_group = cur.addr[GROUP_LSB +: GROUP_W];
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			secured_region_mode   <= 1'b0;
			secured_region_locked <= 1'b0;
		end else if (ans_ok) begin
			if (cur.op == FSP_OP_ENTER)
				secured_region_mode <= 1'b1;
			else if (cur.op == FSP_OP_EXIT)
				secured_region_mode <= 1'b0;
			if (vfy_done && secured_region_mode)
				secured_region_locked <= cyc_rdata[TOP_BIT] | secured_region_locked;
		end
	end
	// Mirror of the flash's flags, learnt by verify reads
	genvar g;
	for (g = 0; g < NUM_GROUPS; g++) begin : g_prot
		always_ff @(posedge core_clk) begin
			if (!rstn)
				group_protected[g] <= 1'b0;
			else if (vfy_done && !secured_region_mode && (cur_group == GROUP_W'(g)))
				group_protected[g] <= vfy_prot;
		end
	end
	// ----------------------------------------
	// Bus cycle engine
	// ----------------------------------------
	fsp_cycle u_cycle (
		.core_clk (core_clk),
		.rstn     (rstn),
		.start    (cyc_start),
		.is_write (cyc_write),
		.addr     (cyc_addr),
		.wdata    (cyc_data),
		.dq_in    (dq_in),
		.bus      (bus_i),
		.busy     (cyc_busy),
		.done     (cyc_done),
		.rdata    (cyc_rdata)
	);
	assign flash_bus = bus_i;
endmodule // fsp_host
`default_nettype wire

// ---- design/fsp_pkg.sv ----
// Package for the flash protection host controller.
// Assumes a 200 MHz core clock and a parallel NOR flash on the far side.
`default_nettype none
package fsp_pkg;
	// ----------------------------------------
	// Geometry
	// ----------------------------------------
	localparam int ADDR_W        = 23;
	localparam int DATA_W        = 8;
	localparam int GROUP_LSB     = 18;
	localparam int GROUP_W       = 5;
	localparam int NUM_GROUPS    = 32;
	localparam int SECTORS_PER_G = 4;
	localparam int TOP_BIT       = 7;
	// ----------------------------------------
	// Codes read back by the verify cycle, command bytes and unlock addresses
	// ----------------------------------------
	localparam logic [7:0] VERIFY_PROT   = 8'h80;
	localparam logic [7:0] VERIFY_UNPROT = 8'h00;
	localparam logic [7:0] CMD_ENTER_1   = 8'hAA;
	localparam logic [7:0] CMD_ENTER_2   = 8'h55;
	localparam logic [7:0] CMD_ENTER_3   = 8'h88;
	localparam logic [7:0] CMD_EXIT_4    = 8'h00;
	localparam logic [7:0] CMD_EXIT_3    = 8'h90;
	localparam logic [22:0] UNLOCK_A1    = 23'h00_0AAA;
	localparam logic [22:0] UNLOCK_A2    = 23'h00_0555;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_PS  = 5000;
	localparam int GLITCH_NS      = 5;
	localparam int GLITCH_CYC_RAW = (GLITCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int STROBE_CYC     = (GLITCH_CYC_RAW < 1) ? 4 : GLITCH_CYC_RAW * 4;
	localparam logic [7:0] STROBE_CNT = 8'(STROBE_CYC);
	// ----------------------------------------
	// Commands from the user side
	// ----------------------------------------
	typedef enum logic [2:0] {
		FSP_OP_READ   = 3'h0,
		FSP_OP_WRITE  = 3'h1,
		FSP_OP_ENTER  = 3'h2,
		FSP_OP_EXIT   = 3'h3,
		FSP_OP_VERIFY = 3'h4
	} fsp_op_t;
	typedef struct packed {
		fsp_op_t           op;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} fsp_req_t;
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dq_out;
		logic              dq_oe_n;
		logic              ce_n;
		logic              oe_n;
		logic              we_n;
	} fsp_bus_t;
endpackage : fsp_pkg
`default_nettype wire

// ---- verification/fsp_assertions.sv ----
// Port checker for fsp_host, attached by bind.
// Assumes one clock domain and the contract latencies.
`default_nettype none
module fsp_chk
	import fsp_pkg::*;
(
	input wire logic                 core_clk,
	input wire logic                 rstn,
	input wire logic                 req_valid,
	input wire fsp_pkg::fsp_req_t    req,
	input wire logic                 req_ready,
	input wire logic                 resp_valid,
	input wire logic [7:0]           resp_data,
	input wire logic                 resp_refused,
	input wire logic                 temp_unprotect,
	input wire logic                 supply_ok,
	input wire logic [31:0]          group_protected,
	input wire logic                 secured_region_mode,
	input wire logic                 secured_region_locked,
	input wire fsp_pkg::fsp_bus_t    flash_bus,
	input wire logic                 flash_reset_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// Answer latency: two screening cycles plus one span per bus cycle
	localparam int BUS_CYC   = STROBE_CYC + 3;
	localparam int ANS_ONE   = 2 + BUS_CYC;
	localparam int ANS_ENTER = 2 + 3 * BUS_CYC;
	localparam int ANS_EXIT  = 2 + 4 * BUS_CYC;
	logic [7:0] lo_cnt;
	logic [4:0] grp;
	wire        take = req_valid && req_ready;
	always_ff @(posedge core_clk) begin
		if (!rstn || flash_bus.ce_n) lo_cnt <= 8'h00;
		else lo_cnt <= lo_cnt + 8'h01;
	end
	always_ff @(posedge core_clk) begin
		if (take) grp <= req.addr[22:18];
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	sequence s_take(fsp_op_t o); take && req.op == o; endsequence
	sequence s_refused; resp_valid && resp_refused; endsequence
	AST_LOW_SUPPLY: assert property (s_take(FSP_OP_WRITE) ##0 !supply_ok
		|=> flash_bus.we_n[*2] ##0 s_refused) else $error("low supply write went out");
	AST_PROT_WRITE: assert property (s_take(FSP_OP_WRITE) ##0
		(group_protected[req.addr[22:18]] && !temp_unprotect) |-> ##2 s_refused)
		else $error("protected write not refused");
	AST_TEMP_OPEN: assert property (s_take(FSP_OP_WRITE) ##0
		(supply_ok && temp_unprotect && !secured_region_mode)
		|-> ##ANS_ONE (resp_valid && !resp_refused)) else $error("temp unprotect write lost");
	AST_LOCKED: assert property (s_take(FSP_OP_WRITE) ##0 (secured_region_mode &&
		secured_region_locked && req.addr[22:18] == 5'h00) |-> ##2 s_refused)
		else $error("locked region write not refused");
	AST_WRITE_LEVEL: assert property (!flash_bus.we_n |->
		!flash_bus.ce_n && flash_bus.oe_n && !flash_bus.dq_oe_n) else $error("bad write levels");
	AST_STROBE_WIDTH: assert property ($rose(flash_bus.ce_n) |-> lo_cnt == STROBE_CNT)
		else $error("strobe width wrong");
	AST_VERIFY_MIRROR: assert property (s_take(FSP_OP_VERIFY) ##0 !secured_region_mode
		|-> ##ANS_ONE resp_valid ##1 (group_protected[grp] == (resp_data == VERIFY_PROT)))
		else $error("verify mirror wrong");
	AST_ENTER_FIRST: assert property (s_take(FSP_OP_ENTER) |-> ##3 (!flash_bus.we_n &&
		flash_bus.addr == UNLOCK_A1 && flash_bus.dq_out == CMD_ENTER_1))
		else $error("enter first cycle wrong");
	AST_ENTER_MODE: assert property (s_take(FSP_OP_ENTER)
		|-> ##ANS_ENTER resp_valid ##1 secured_region_mode) else $error("enter mode missing");
	AST_EXIT_MODE: assert property (s_take(FSP_OP_EXIT)
		|-> ##ANS_EXIT resp_valid ##1 !secured_region_mode) else $error("exit mode stuck");
	AST_RESET_MODE: assert property ($rose(rstn) |->
		(!secured_region_mode && !flash_reset_n) ##1 flash_reset_n) else $error("reset exit bad");
endmodule // fsp_chk
bind fsp_host fsp_chk u_fsp_chk (.core_clk(core_clk), .rstn(rstn), .req_valid(req_valid),
	.req(req), .req_ready(req_ready), .resp_valid(resp_valid), .resp_data(resp_data),
	.resp_refused(resp_refused), .temp_unprotect(temp_unprotect), .supply_ok(supply_ok),
	.group_protected(group_protected), .secured_region_mode(secured_region_mode),
	.secured_region_locked(secured_region_locked), .flash_bus(flash_bus),
	.flash_reset_n(flash_reset_n));
`default_nettype wire

// ---- verification/fsp_flash_model.sv ----
// Behavioural flash: group flags, secured region, write screening.
// Assumes the host strobes from core_clk edges.
`default_nettype none
module fsp_flash_model
	import fsp_pkg::*;
#(
	parameter logic [31:0] PROT       = 32'h8000_0020,
	parameter logic        LOCKED_IND = 1'b1
)(
	input wire logic              core_clk,
	input wire fsp_pkg::fsp_bus_t bus,
	input wire logic              reset_n,
	input wire logic              high_volt,
	input wire logic              supply_ok,
	output logic [7:0]            dq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] step = 2'h0;
	logic       sec = 1'b0;
	logic [7:0] last = 8'h00;
	int         lo = 0;
	int         n_writes = 0;
	int         n_blocked = 0;
	wire        rd = !bus.ce_n && !bus.oe_n && bus.we_n;
	wire        blk = sec ? LOCKED_IND : PROT[bus.addr[22:18]] && !high_volt;
	wire  [7:0] val = sec ? {LOCKED_IND, 7'h10} :
		(PROT[bus.addr[22:18]] ? VERIFY_PROT : VERIFY_UNPROT);
	assign dq = rd ? val : ~last;
	always @(posedge core_clk) begin
		if (rd) last <= val;
		lo <= (!bus.we_n && !bus.ce_n && bus.oe_n) ? lo + 1 : 0;
		if (!reset_n) begin
			sec <= 1'b0;
			step <= 2'h0;
		end else if (!supply_ok) begin
			step <= 2'h0;
		end else if ($rose(bus.we_n) && lo > 1) begin
			if (blk) n_blocked <= n_blocked + 1;
			else n_writes <= n_writes + 1;
			if (bus.dq_out == CMD_ENTER_1) step <= 2'h1;
			else if (step == 2'h1 && bus.dq_out == CMD_ENTER_2) step <= 2'h2;
			else if (step == 2'h2 && bus.dq_out == CMD_ENTER_3) sec <= 1'b1;
			else if (step == 2'h2 && bus.dq_out == CMD_EXIT_3) step <= 2'h3;
			else if (step == 2'h3) sec <= 1'b0;
		end
	end
endmodule // fsp_flash_model
`default_nettype wire

// ---- verification/test_flash_sector_protection_secure_region.sv ----
// Self-checking bench for fsp_host against the flash model.
// Assumes the checker is bound to fsp_host.
`default_nettype none
module test_flash_sector_protection_secure_region;
	timeunit 1ns;
	timeprecision 1ps;
	import fsp_pkg::*;
	logic core_clk = 1'b0, rstn = 1'b0, req_valid = 1'b0, req_ready, resp_valid, resp_refused;
	logic temp_unprotect = 1'b0, supply_ok = 1'b1, srm, srl, flash_reset_n;
	logic [7:0] resp_data, dq_in;
	logic [31:0] group_protected;
	fsp_req_t req = '0;
	fsp_bus_t flash_bus;
	int fail_count = 0, n_checks = 0, nw;
	always #2.5 core_clk = ~core_clk;
	fsp_host u_fsp_host (.core_clk(core_clk), .rstn(rstn), .req_valid(req_valid), .req(req),
		.req_ready(req_ready), .resp_valid(resp_valid), .resp_data(resp_data),
		.resp_refused(resp_refused), .temp_unprotect(temp_unprotect), .supply_ok(supply_ok),
		.group_protected(group_protected), .secured_region_mode(srm),
		.secured_region_locked(srl), .dq_in(dq_in), .flash_bus(flash_bus),
		.flash_reset_n(flash_reset_n));
	fsp_flash_model u_fsp_flash_model (.core_clk(core_clk), .bus(flash_bus),
		.reset_n(flash_reset_n), .high_volt(temp_unprotect), .supply_ok(supply_ok), .dq(dq_in));
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic op(fsp_op_t o, logic [22:0] a, logic [7:0] d);
		int k;
		k = 0;
		@(posedge core_clk);
		req_valid <= 1'b1;
		req <= '{o, a, d};
		@(posedge core_clk);
		while (!req_ready && k < 100) begin @(posedge core_clk); k++; end
		req_valid <= 1'b0;
		chk("req taken", 1, req_ready);
		while (!resp_valid && k < 300) begin @(posedge core_clk); k++; end
		chk("answer", 1, resp_valid);
		@(posedge core_clk);
	endtask
	task automatic do_reset();
		rstn <= 1'b0;
		repeat (5) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (2) @(posedge core_clk);
		chk("reset pin", 1, flash_reset_n);
		chk("mode", 0, srm);
	endtask
	task automatic t_verify();
		op(FSP_OP_READ, 23'h14_0000, 8'h00);
		chk("read data", VERIFY_PROT, resp_data);
		chk("read no learn", 0, group_protected);
		op(FSP_OP_VERIFY, 23'h14_0000, 8'h00);
		chk("verify g5", VERIFY_PROT, resp_data);
		op(FSP_OP_VERIFY, 23'h18_0000, 8'h00);
		chk("verify g6", VERIFY_UNPROT, resp_data);
		op(FSP_OP_VERIFY, 23'h7F_FFFF, 8'h00);
		chk("verify g31", VERIFY_PROT, resp_data);
		chk("mirror", 32'h8000_0020, group_protected);
	endtask
	task automatic t_prot();
		nw = u_fsp_flash_model.n_writes;
		for (int s = 0; s < 4; s++) begin
			op(FSP_OP_WRITE, {5'h05, 2'(s), 16'h0000}, 8'h11);
			chk("sector refused", 1, resp_refused);
		end
		supply_ok <= 1'b0;
		op(FSP_OP_WRITE, 23'h18_0000, 8'h22);
		chk("low supply", 1, resp_refused);
		supply_ok <= 1'b1;
		chk("no bus write", nw, u_fsp_flash_model.n_writes);
		temp_unprotect <= 1'b1;
		op(FSP_OP_WRITE, 23'h14_0010, 8'h33);
		chk("temp open", 0, resp_refused);
		chk("write seen", nw + 1, u_fsp_flash_model.n_writes);
		temp_unprotect <= 1'b0;
		op(FSP_OP_WRITE, 23'h14_0010, 8'h44);
		chk("restored", 1, resp_refused);
		chk("flag kept", 1, group_protected[5]);
		chk("device blocks", 0, u_fsp_flash_model.n_blocked);
	endtask
	task automatic t_secured();
		op(FSP_OP_ENTER, 23'h00_0000, 8'h00);
		chk("enter", 1, srm);
		op(FSP_OP_VERIFY, 23'h00_0000, 8'h00);
		chk("indicator", 1, resp_data[TOP_BIT]);
		chk("locked", 1, srl);
		op(FSP_OP_WRITE, 23'h00_0005, 8'h55);
		chk("locked write", 1, resp_refused);
		op(FSP_OP_EXIT, 23'h00_0000, 8'h00);
		chk("exit", 0, srm);
		op(FSP_OP_ENTER, 23'h00_0000, 8'h00);
		do_reset();
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge core_clk);
		fail_count++;
		print_verdict();
	end
	initial begin
		do_reset();
		t_verify();
		t_prot();
		t_secured();
		print_verdict();
	end
endmodule // test_flash_sector_protection_secure_region
`default_nettype wire
